//--- design/motion_transient_regs.svh
`ifndef MOTION_TRANSIENT_REGS_SVH
`define MOTION_TRANSIENT_REGS_SVH

// ==================================================
// register offsets
`define MOTION_THRESHOLD_ADDR      8'h17
`define MOTION_DEBOUNCE_COUNT_ADDR 8'h18
`define TRANSIENT_CONFIG_ADDR      8'h1d
`define TRANSIENT_SOURCE_ADDR      8'h1e

// ==================================================
// reset values
`define MOTION_THRESHOLD_RST       8'h00
`define MOTION_DEBOUNCE_COUNT_RST  8'h00
`define TRANSIENT_CONFIG_RST       8'h00
`define TRANSIENT_SOURCE_RST       8'h00

// ==================================================
// field positions
`define DEBOUNCE_MODE_BIT          7
`define HIGHPASS_BYPASS_BIT        0
`define LATCH_ENABLE_BIT           4
`define EVENT_ACTIVE_BIT           6
`define Z_CHANGE_ENABLE_BIT        3
`define Y_CHANGE_ENABLE_BIT        2
`define X_CHANGE_ENABLE_BIT        1

// ==================================================
// threshold limits, 0.063 g per count
`define THRESHOLD_MAX              7'h7f
`define LOW_NOISE_THRESHOLD_MAX    7'h3f

// ==================================================
// debounce time steps in microseconds
`define STEP_800HZ_US              18'd1250
`define STEP_400HZ_US              18'd2500
`define STEP_200HZ_US              18'd5000
`define STEP_100HZ_US              18'd10000
`define STEP_50HZ_US               18'd20000
`define STEP_LONG_US               18'd80000
`define STEP_LONGEST_US            18'd160000

`endif

//--- design/motion_transient_pkg.sv
package motion_transient_pkg;

  // ==================================================
  // one sample of three axes, two's complement
  typedef struct packed {
    logic signed [9:0] x;
    logic signed [9:0] y;
    logic signed [9:0] z;
  } accel_axes_type;

  // output sample rate codes, fastest first
  typedef enum logic [2:0] {
    RATE_800HZ  = 3'h0,
    RATE_400HZ  = 3'h1,
    RATE_200HZ  = 3'h2,
    RATE_100HZ  = 3'h3,
    RATE_50HZ   = 3'h4,
    RATE_12HZ5  = 3'h5,
    RATE_6HZ25  = 3'h6,
    RATE_1HZ56  = 3'h7
  } output_sample_rate_type;

  // oversampling modes
  typedef enum logic [1:0] {
    MODE_NORMAL                   = 2'h0,
    MODE_LOW_POWER_LOW_NOISE_MODE = 2'h1,
    MODE_HIGH_RESOLUTION_MODE     = 2'h2,
    MODE_POWER_SAVING_MODE        = 2'h3
  } oversample_mode_type;

  // full scale range
  typedef enum logic [1:0] {
    RANGE_2G = 2'h0,
    RANGE_4G = 2'h1,
    RANGE_8G = 2'h2
  } full_scale_type;

endpackage

//--- design/motion_transient_event_detect.sv
`timescale 1ns/10ps
`include "motion_transient_regs.svh"

module motion_transient_event_detect (
  // clock and reset
  input  wire logic                                        clk_sys,
  input  wire logic                                        arst_n,
  // register port
  input  wire logic [7:0]                                  reg_addr,
  input  wire logic                                        reg_wr,
  input  wire logic                                        reg_rd,
  input  wire logic [7:0]                                  reg_wdata,
  output logic      [7:0]                                  reg_rdata,
  // sample stream
  input  wire logic                                        sample_valid,
  input  wire motion_transient_pkg::accel_axes_type        accel_raw,
  input  wire motion_transient_pkg::accel_axes_type        accel_highpass,
  // settings held elsewhere in the device
  input  wire motion_transient_pkg::full_scale_type        full_scale,
  input  wire logic                                        low_noise,
  input  wire motion_transient_pkg::output_sample_rate_type output_sample_rate,
  input  wire motion_transient_pkg::oversample_mode_type   oversample_mode,
  input  wire logic [2:0]                                  motion_axis_enable,
  input  wire logic                                        motion_or_select,
  input  wire logic [7:0]                                  transient_limit,
  input  wire logic [7:0]                                  transient_count,
  // events
  output logic                                             motion_event,
  output logic                                             transient_event,
  output logic                                             transient_irq,
  output logic      [17:0]                                 debounce_step_us
);
  import motion_transient_pkg::*;

  // ==================================================
  // helper functions

  // magnitude of a ten bit sample; -512 maps to 512 unsigned
  function automatic logic [9:0] magnitude(input logic signed [9:0] a);
    logic [9:0] r;
    r = a[9] ? 10'(-a) : 10'(a);
    return r;
  endfunction

  // threshold in data counts; never clipped by range, capped by low noise
  function automatic logic [10:0] scale_threshold(input logic [6:0] ths,
                                                  input full_scale_type fs,
                                                  input logic lnoise);
    logic [6:0]  t;
    logic [10:0] r;
    t = (lnoise && ths > `LOW_NOISE_THRESHOLD_MAX) ? `LOW_NOISE_THRESHOLD_MAX : ths;
    // one threshold count is sixteen data counts at 2 g, eight at 4 g, four at 8 g
    case (fs)
      RANGE_2G: r = {t, 4'h0};
      RANGE_4G: r = {1'b0, t, 3'h0};
      default:  r = {2'h0, t, 2'h0};
    endcase
    return r;
  endfunction

  // per-axis compare, bit 2 is Z, bit 1 Y, bit 0 X
  function automatic logic [2:0] above(input accel_axes_type a,
                                       input logic [10:0] thr);
    logic [2:0] r;
    r[2] = {1'b0, magnitude(a.z)} > thr;
    r[1] = {1'b0, magnitude(a.y)} > thr;
    r[0] = {1'b0, magnitude(a.x)} > thr;
    return r;
  endfunction

  // next debounce counter value for one sample
  function automatic logic [7:0] debounce_next(input logic [7:0] cnt,
                                               input logic [7:0] limit,
                                               input logic cond,
                                               input logic clear_mode);
    logic [7:0] r;
    // a count lowered below the counter pulls it straight down
    if (cnt > limit) begin
      r = limit;
    end else if (cond) begin
      r = (cnt < limit) ? 8'(cnt + 8'h01) : limit;
    end else if (clear_mode) begin
      r = 8'h00;
    end else begin
      r = (cnt != 8'h00) ? 8'(cnt - 8'h01) : 8'h00;
    end
    return r;
  endfunction

  // debounce time step for a rate and oversampling mode
  function automatic logic [17:0] step_time(input output_sample_rate_type rate,
                                            input oversample_mode_type mode);
    logic [17:0] r;
    case (rate)
      RATE_800HZ: r = `STEP_800HZ_US;
      RATE_400HZ: r = `STEP_400HZ_US;
      RATE_200HZ: r = `STEP_200HZ_US;
      RATE_100HZ: r = `STEP_100HZ_US;
      RATE_50HZ:  r = `STEP_50HZ_US;
      RATE_12HZ5: r = `STEP_LONG_US;
      default:    r = `STEP_LONGEST_US;
    endcase
    case (mode)
      MODE_NORMAL: begin
        if (r > `STEP_50HZ_US) r = `STEP_50HZ_US;
      end
      MODE_LOW_POWER_LOW_NOISE_MODE: begin
        if (r > `STEP_LONG_US) r = `STEP_LONG_US;
      end
      MODE_HIGH_RESOLUTION_MODE: begin
        if (r > `STEP_400HZ_US) r = `STEP_400HZ_US;
      end
      default: begin
      end
    endcase
    return r;
  endfunction

  // ==================================================
  // register state
  logic [7:0] motion_threshold_q;
  logic [7:0] motion_debounce_count_q;
  logic [7:0] transient_config_q;
  logic [7:0] transient_source_q;
  logic [7:0] transient_source_d;
  logic [7:0] reg_rdata_q;
  logic [7:0] reg_rdata_d;
  logic [7:0] motion_cnt_q;
  logic [7:0] motion_cnt_d;
  logic [7:0] transient_cnt_q;
  logic [7:0] transient_cnt_d;
  logic       motion_event_q;
  logic       transient_event_q;
  // the step is reported only; the sample strobe itself sets the pace
  logic [17:0] step_q;

  // ==================================================
  // address decode
  wire sel_threshold = (reg_addr == `MOTION_THRESHOLD_ADDR);
  wire sel_count     = (reg_addr == `MOTION_DEBOUNCE_COUNT_ADDR);
  wire sel_config    = (reg_addr == `TRANSIENT_CONFIG_ADDR);
  wire sel_source    = (reg_addr == `TRANSIENT_SOURCE_ADDR);
  wire source_read   = reg_rd && sel_source;

  // unused config bits 7..5 always read zero
  wire [7:0] config_wmask = 8'h1f;

  // ==================================================
  // config fields
  wire debounce_mode_select = motion_threshold_q[`DEBOUNCE_MODE_BIT];
  wire [6:0] threshold_value = motion_threshold_q[6:0];
  wire highpass_bypass = transient_config_q[`HIGHPASS_BYPASS_BIT];
  wire latch_enable = transient_config_q[`LATCH_ENABLE_BIT];
  wire z_change_flag_enable = transient_config_q[`Z_CHANGE_ENABLE_BIT];
  wire y_change_flag_enable = transient_config_q[`Y_CHANGE_ENABLE_BIT];
  wire x_change_flag_enable = transient_config_q[`X_CHANGE_ENABLE_BIT];
  // packed Z, Y, X so it lines up with the per-axis compare result
  wire [2:0] change_flag_enable = {z_change_flag_enable, y_change_flag_enable,
                                   x_change_flag_enable};

  // ==================================================
  // motion / freefall condition
  wire [10:0] motion_thr = scale_threshold(threshold_value, full_scale, low_noise);
  wire [2:0]  motion_above = above(accel_raw, motion_thr);
  wire        motion_any = |(motion_above & motion_axis_enable);
  // freefall needs at least one enabled axis to mean anything
  wire        motion_all_low = (motion_axis_enable != 3'h0) &&
                               ((motion_above & motion_axis_enable) == 3'h0);
  wire        motion_cond = motion_or_select ? motion_any : motion_all_low;

  // ==================================================
  // transient condition
  // bypass selects raw data, otherwise the high-pass output
  wire accel_axes_type trans_data = highpass_bypass ? accel_raw : accel_highpass;
  wire [10:0] trans_thr = scale_threshold(transient_limit[6:0], full_scale, low_noise);
  wire [2:0]  trans_above = above(trans_data, trans_thr) & change_flag_enable;
  wire        trans_cond = |trans_above;
  // the transient detector carries its own mode bit in its limit byte
  wire        trans_clear_mode = transient_limit[`DEBOUNCE_MODE_BIT];
  wire [2:0]  trans_sign = {trans_data.z[9], trans_data.y[9], trans_data.x[9]};

  // ==================================================
  // debounce counters move only on an output sample
  assign motion_cnt_d = sample_valid ?
    debounce_next(motion_cnt_q, motion_debounce_count_q, motion_cond, debounce_mode_select) :
    motion_cnt_q;
  assign transient_cnt_d = sample_valid ?
    debounce_next(transient_cnt_q, transient_count, trans_cond, trans_clear_mode) :
    transient_cnt_q;

  // events fire on every matching sample that leaves the counter at the count
  // a count of zero makes every matching sample an event
  wire motion_hit = sample_valid && motion_cond &&
                    (motion_cnt_d == motion_debounce_count_q);
  wire trans_hit  = sample_valid && trans_cond &&
                    (transient_cnt_d == transient_count);

  // ==================================================
  // transient source next state
  // fresh pairs: event bit and polarity per axis, Z in the high pair
  wire [5:0] hit_pairs = trans_hit ?
    {trans_above[2], trans_above[2] & trans_sign[2],
     trans_above[1], trans_above[1] & trans_sign[1],
     trans_above[0], trans_above[0] & trans_sign[0]} : 6'h00;
  wire [2:0] old_events = {transient_source_q[5], transient_source_q[3],
                           transient_source_q[1]};
  wire       old_active = transient_source_q[`EVENT_ACTIVE_BIT];
  // axes newly raised while latched; these may still renew polarity
  wire [2:0] new_events = {hit_pairs[5], hit_pairs[3], hit_pairs[1]} & ~old_events;
  wire [5:0] new_mask = {{2{new_events[2]}}, {2{new_events[1]}}, {2{new_events[0]}}};
  // a read clears first, then a same-cycle hit sets again so no event is lost
  wire [5:0] base_pairs = source_read ? 6'h00 : transient_source_q[5:0];
  wire [5:0] held_pairs = (source_read || !old_active) ? hit_pairs | base_pairs :
                          (base_pairs & ~new_mask) | (hit_pairs & new_mask);
  // live view keeps the last hit until the next sample or a source read
  wire [5:0] live_pairs = sample_valid ? hit_pairs : base_pairs;
  wire [5:0] next_pairs = latch_enable ? held_pairs : live_pairs;
  wire       next_active = |{next_pairs[5], next_pairs[3], next_pairs[1]};
  assign transient_source_d = {1'b0, next_active, next_pairs};

  // ==================================================
  // read data mux; unmapped offsets read zero
  assign reg_rdata_d = sel_threshold ? motion_threshold_q :
                       sel_count     ? motion_debounce_count_q :
                       sel_config    ? transient_config_q :
                       sel_source    ? transient_source_q :
                       8'h00;

  // ==================================================
  // software registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      motion_threshold_q      <= `MOTION_THRESHOLD_RST;
      motion_debounce_count_q <= `MOTION_DEBOUNCE_COUNT_RST;
      transient_config_q      <= `TRANSIENT_CONFIG_RST;
    end else if (reg_wr) begin
      // writes to the source or to unmapped offsets fall through
      if (sel_threshold) motion_threshold_q <= reg_wdata;
      if (sel_count) motion_debounce_count_q <= reg_wdata;
      if (sel_config) transient_config_q <= reg_wdata & config_wmask;
    end
  end

  // read capture happens before the clear, so software sees the flags
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // ==================================================
  // detector state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      motion_cnt_q       <= 8'h00;
      transient_cnt_q    <= 8'h00;
      transient_source_q <= `TRANSIENT_SOURCE_RST;
      motion_event_q     <= 1'b0;
      transient_event_q  <= 1'b0;
      step_q             <= `STEP_800HZ_US;
    end else begin
      motion_cnt_q       <= motion_cnt_d;
      transient_cnt_q    <= transient_cnt_d;
      transient_source_q <= transient_source_d;
      motion_event_q     <= motion_hit;
      transient_event_q  <= trans_hit;
      step_q             <= step_time(output_sample_rate, oversample_mode);
    end
  end

  // ==================================================
  // outputs
  assign reg_rdata        = reg_rdata_q;
  assign motion_event     = motion_event_q;
  assign transient_event  = transient_event_q;
  // irq follows event active directly, so a source read drops it at once
  assign transient_irq    = transient_source_q[`EVENT_ACTIVE_BIT];
  assign debounce_step_us = step_q;

endmodule

//--- tb/motion_transient_checker.sv
`timescale 1ns/10ps
`include "motion_transient_regs.svh"
// ==================================================
// port-level checks of the event detector
module motion_transient_checker (
  // clock and reset
  input wire logic                                         clk_sys,
  input wire logic                                         arst_n,
  // register port
  input wire logic [7:0]                                   reg_addr,
  input wire logic                                         reg_wr,
  input wire logic                                         reg_rd,
  input wire logic [7:0]                                   reg_wdata,
  input wire logic [7:0]                                   reg_rdata,
  // samples and settings
  input wire logic                                         sample_valid,
  input wire motion_transient_pkg::output_sample_rate_type output_sample_rate,
  input wire motion_transient_pkg::oversample_mode_type    oversample_mode,
  // events
  input wire logic                                         motion_event,
  input wire logic                                         transient_event,
  input wire logic                                         transient_irq,
  input wire logic [17:0]                                  debounce_step_us
);
  import motion_transient_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // a source read is a read strobe at the source offset
  wire src_rd = reg_rd && (reg_addr == `TRANSIENT_SOURCE_ADDR);
  wire thr_wr = reg_wr && !reg_rd && (reg_addr == `MOTION_THRESHOLD_ADDR);
  wire thr_rd = reg_rd && !reg_wr && (reg_addr == `MOTION_THRESHOLD_ADDR);
  AST_SRC_TOP_ZERO: assert property (src_rd |=> reg_rdata[7] == 1'b0 &&
      reg_rdata[6] == (reg_rdata[5] | reg_rdata[3] | reg_rdata[1]))
    else $error("source bit 7 set or event active disagrees with axis flags");
  AST_POLARITY_WITH_EVENT: assert property (src_rd |=>
      (reg_rdata[4] & ~reg_rdata[5]) == 1'b0 && (reg_rdata[2] & ~reg_rdata[3]) == 1'b0 &&
      (reg_rdata[0] & ~reg_rdata[1]) == 1'b0)
    else $error("polarity bit set without its axis event");
  AST_ACTIVE_IS_IRQ: assert property (src_rd |=> reg_rdata[6] == $past(transient_irq))
    else $error("event active bit differs from transient irq");
  // a sample in the read cycle may set the source again, so only clean reads count
  AST_READ_CLEARS: assert property (src_rd && !sample_valid |=> !transient_irq)
    else $error("transient irq survived a source read");
  AST_IRQ_HOLDS: assert property (!sample_valid && !src_rd |=> $stable(transient_irq))
    else $error("transient irq moved without sample or read");
  AST_MOTION_ON_SAMPLE: assert property ($rose(motion_event) |->
      $past(sample_valid) || $past(sample_valid, 2))
    else $error("motion event without a sample");
  AST_TRANSIENT_ON_SAMPLE: assert property ($rose(transient_event) |->
      $past(sample_valid) || $past(sample_valid, 2))
    else $error("transient event without a sample");
  AST_THRESHOLD_READBACK: assert property (thr_wr ##1 !reg_wr ##1 thr_rd |=>
      reg_rdata == $past(reg_wdata, 3))
    else $error("threshold register lost written value");
  AST_STEP_FASTEST: assert property (output_sample_rate == RATE_800HZ |=>
      debounce_step_us == 18'd1250)
    else $error("step at fastest rate wrong");
  AST_STEP_HIGH_RESOLUTION_MODE: assert property (oversample_mode == MODE_HIGH_RESOLUTION_MODE |=>
      debounce_step_us <= 18'd2500)
    else $error("high resolution step too long");
  AST_STEP_SLOWEST: assert property (oversample_mode == MODE_POWER_SAVING_MODE &&
      output_sample_rate == RATE_1HZ56 |=> debounce_step_us == 18'd160000)
    else $error("power saving slowest step wrong");
endmodule

bind motion_transient_event_detect motion_transient_checker chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sample_valid(sample_valid), .output_sample_rate(output_sample_rate),
  .oversample_mode(oversample_mode), .motion_event(motion_event),
  .transient_event(transient_event), .transient_irq(transient_irq),
  .debounce_step_us(debounce_step_us));

//--- tb/host_model.sv
`timescale 1ns/10ps
// ==================================================
// host software side of the register port
module host_model (
  // clock
  input  wire logic       clk_sys,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // strobes idle low from time zero so nothing is taken in reset
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // called at a falling edge; an idle cycle follows so strobes never retoggle in one step
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_wdata = ~data; // stale data must not look valid
    @(negedge clk_sys);
  endtask
  // read data lands one edge after the strobe
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    data   = reg_rdata;
    @(negedge clk_sys);
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
  import motion_transient_pkg::*;
  // ==================================================
  // bench signals
  logic                   clk_sys = 1'b0;
  logic                   arst_n = 1'b0;
  logic [7:0]             reg_addr, reg_wdata, reg_rdata, rd;
  logic                   reg_wr, reg_rd, mev, tev;
  logic                   sample_valid = 1'b0;
  accel_axes_type         accel_raw = '0;
  accel_axes_type         accel_highpass = '0;
  full_scale_type         full_scale = RANGE_2G;
  logic                   low_noise = 1'b0;
  output_sample_rate_type output_sample_rate = RATE_800HZ;
  oversample_mode_type    oversample_mode = MODE_NORMAL;
  logic [2:0]             motion_axis_enable = 3'h1;
  logic                   motion_or_select = 1'b1;
  logic [7:0]             transient_limit = 8'h01;
  logic [7:0]             transient_count = 8'h00;
  logic                   motion_event, transient_event, transient_irq;
  logic [17:0]            debounce_step_us;
  int                     n_fail = 0;
  int                     checked = 0;
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin \
  $display("MISMATCH %s expected %0h seen %0h", what, exp, got); n_fail++; end end
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  motion_transient_event_detect dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .accel_raw(accel_raw), .accel_highpass(accel_highpass),
    .full_scale(full_scale), .low_noise(low_noise), .output_sample_rate(output_sample_rate),
    .oversample_mode(oversample_mode), .motion_axis_enable(motion_axis_enable),
    .motion_or_select(motion_or_select), .transient_limit(transient_limit),
    .transient_count(transient_count), .motion_event(motion_event),
    .transient_event(transient_event), .transient_irq(transient_irq),
    .debounce_step_us(debounce_step_us));
  // ==================================================
  // one sample; events may land one or two edges later
  task automatic smp(input accel_axes_type raw, input accel_axes_type hp);
    accel_raw      = raw;
    accel_highpass = hp;
    sample_valid   = 1'b1;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    mev = motion_event;
    tev = transient_event;
    @(negedge clk_sys);
    mev = mev | motion_event;
    tev = tev | transient_event;
  endtask
  task automatic test_regs();
    logic [7:0] a [5] = '{8'h17, 8'h18, 8'h1d, 8'h1e, 8'h00};
    foreach (a[i]) begin
      host.read(a[i], rd);
      `CHK("reset value", 8'h00, rd)
    end
    host.write(8'h18, 8'ha5);
    host.read(8'h18, rd);
    `CHK("count readback", 8'ha5, rd)
    host.write(8'h17, 8'h85);
    host.read(8'h17, rd);
    `CHK("threshold readback", 8'h85, rd)
    host.write(8'h1e, 8'hff);
    host.write(8'h00, 8'hff);
    host.read(8'h1e, rd);
    `CHK("source after write", 8'h00, rd)
    host.read(8'h00, rd);
    `CHK("unmapped read", 8'h00, rd)
    host.write(8'h1d, 8'hf6);
    host.read(8'h1d, rd);
    `CHK("config readback", 8'h16, rd)
    $display("test registers done");
  endtask
  task automatic test_motion();
    bit c [8] = '{1, 1, 1, 0, 1, 0, 1, 1};
    bit e [8] = '{0, 1, 1, 0, 1, 0, 0, 1};
    accel_axes_type big = '{x: 10'sd20, y: 10'sd0, z: 10'sd0};
    host.write(8'h1d, 8'h00);
    host.write(8'h17, 8'h01);
    host.write(8'h18, 8'h02);
    for (int i = 0; i < 8; i++) begin
      if (i == 5) host.write(8'h17, 8'h81);
      smp(c[i] ? big : '0, '0);
      `CHK("motion event", e[i], mev)
    end
    host.write(8'h18, 8'h00);
    motion_or_select   = 1'b0;
    motion_axis_enable = 3'h7;
    smp('0, '0);
    `CHK("freefall quiet", 1'b1, mev)
    smp(big, '0);
    `CHK("freefall broken", 1'b0, mev)
    motion_or_select = 1'b1;
    full_scale       = RANGE_8G;
    low_noise        = 1'b1;
    host.write(8'h17, 8'h7f);
    big.x = 10'sd300;
    smp(big, '0);
    `CHK("low noise clamp", 1'b1, mev)
    low_noise = 1'b0;
    smp(big, '0);
    `CHK("full threshold", 1'b0, mev)
    full_scale = RANGE_2G;
    $display("test motion done");
  endtask
  task automatic test_transient();
    accel_axes_type xn = '{x: -10'sd20, y: 10'sd0, z: 10'sd0};
    accel_axes_type pp = '{x: 10'sd20, y: 10'sd20, z: 10'sd0};
    accel_axes_type zp = '{x: 10'sd0, y: 10'sd0, z: 10'sd20};
    bit q [4] = '{1, 1, 0, 1};
    bit ev [4] = '{0, 1, 0, 0};
    motion_axis_enable = 3'h0;
    host.write(8'h1d, 8'h16);
    smp('0, xn);
    `CHK("transient event", 1'b1, tev)
    smp('0, pp);
    smp('0, '0);
    `CHK("irq latched", 1'b1, transient_irq)
    host.read(8'h1e, rd);
    `CHK("latched source", 8'h4b, rd)
    `CHK("irq after read", 1'b0, transient_irq)
    host.read(8'h1e, rd);
    `CHK("source cleared", 8'h00, rd)
    host.write(8'h1d, 8'h09);
    smp(zp, '0);
    host.read(8'h1e, rd);
    `CHK("bypass source", 8'h60, rd)
    smp(zp, '0);
    smp('0, zp);
    host.read(8'h1e, rd);
    `CHK("live source", 8'h00, rd)
    // clear-mode transient debounce, threshold eight counts at 4 g
    transient_limit = 8'h81;
    transient_count = 8'h02;
    full_scale      = RANGE_4G;
    zp.z            = 10'sd10;
    foreach (q[i]) begin
      smp(q[i] ? zp : '0, '0);
      `CHK("transient count", ev[i], tev)
    end
    full_scale = RANGE_2G;
    $display("test transient done");
  endtask
  task automatic test_step();
    logic [17:0] caps [4] = '{18'd20000, 18'd80000, 18'd2500, 18'd160000};
    logic [17:0] base;
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 8; r++) begin
        output_sample_rate = output_sample_rate_type'(3'(r));
        oversample_mode    = oversample_mode_type'(2'(m));
        base = (r <= 4) ? (18'd1250 << r) : (r == 5) ? 18'd80000 : 18'd160000;
        @(negedge clk_sys);
        `CHK("step", (base < caps[m]) ? base : caps[m], debounce_step_us)
      end
    end
    $display("test step done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==================================================
  // main sequence: reset for three cycles, then the tests
  initial begin
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    test_regs();
    test_motion();
    test_transient();
    test_step();
    report_and_stop();
  end
  // the tests need about 134 cycles; a hang is cut well beyond that
  initial begin
    repeat (5000) @(posedge clk_sys);
    $display("watchdog expired");
    n_fail++;
    report_and_stop();
  end
endmodule
